// file: core/rsfm_defs.svh
// Address map, reset values and timing counts of the sensor fault monitor
`ifndef RSFM_DEFS_SVH
`define RSFM_DEFS_SVH

`define RSFM_CLK_NS        5
`define RSFM_CYC_US(t)     (((t) * 1000 + `RSFM_CLK_NS - 1) / `RSFM_CLK_NS)
`define RSFM_CYC_NS(t)     (((t) + `RSFM_CLK_NS - 1) / `RSFM_CLK_NS)

`define RSFM_ADDR_STATUS   7'h0a
`define RSFM_ADDR_TRK_CTRL 7'h0b
`define RSFM_ADDR_DGL      7'h0c
`define RSFM_ADDR_TRK_STAT 7'h0d
`define RSFM_ADDR_FLT_A    7'h0e
`define RSFM_ADDR_FLT_B    7'h0f

`define RSFM_RST_STATUS    8'h00
`define RSFM_RST_TRK_EN    2'h0
`define RSFM_RST_TRK_REF5  2'h0
`define RSFM_RST_TRK_MODE  2'h3
`define RSFM_RST_DGL       4'h0

`define RSFM_TRK_EN_LSB    0
`define RSFM_TRK_REF5_LSB  2
`define RSFM_LS_OC_LSB     4
`define RSFM_STG_LSB       0

`define RSFM_T_HSOC_US     350
`define RSFM_T_LSOC_US     350
`define RSFM_T_STB_US      11
`define RSFM_T_OPEN_US     11
`define RSFM_T_STG_US      500
`define RSFM_T_LEAK_US     97
`define RSFM_T_BLANK_US    240
`define RSFM_T_DGL_MIN_NS  8000
`define RSFM_T_DGL_STEP_NS 500
`define RSFM_T_LAT_MAX_NS  3625

`endif

// file: core/rsfm_pkg.sv
// Types shared by the sensor fault monitor
package rsfm_pkg;

	typedef struct packed {
		logic [3:0] hs_oc;
		logic [3:0] ls_oc;
		logic [3:0] stb;
		logic [3:0] open;
		logic [3:0] stg;
		logic [3:0] leak;
		logic [3:0] therm;
		logic [3:0] sense;
		logic [1:0] trk_ov;
		logic [1:0] trk_uv;
		logic [1:0] trk_oc;
	} rsfm_raw_t;

	typedef struct packed {
		logic       access;
		logic       write;
		logic [6:0] addr;
		logic [7:0] wdata;
	} rsfm_req_t;

endpackage

// file: core/rsfm_top.sv
// Fault filtering, shutdown policy, deglitch and status registers of the sensor interface
//
// Notes on behaviour
// - Low-side overcurrent in status 7:4, low side on
// - Short to ground in status 3:0, low side off
// - Supply pins 0,1 start as tracking regulators
// - Tracker reference VCC, five-volt rail when selected
// - Trackers enabled independently, both off at reset
// - Tracker over/under voltage, overcurrent readable
// - High-side overcurrent disables stage, low-side does not
// - High-side overcurrent confirmed after 350 us persistence
// - Low-side overcurrent confirmed after 350 us persistence
// - Thermal trip always disables the channel stage
// - Faults and protection kept per channel
// - Short to battery disconnects supply after 11 us
// - Open sensor while on, confirmed after 11 us
// - Short to ground while off, after 500 us
// - Open supply pin seen by return open detect
// - Return leakage flagged after 97 us, no shutdown
// - High-side diagnostics blanked for 240 us
// - Decoded signal deglitch 8 to 15.5 us, 4-bit
// - Decode latency under 3.625 us plus deglitch
`timescale 1ns/10ps
`include "rsfm_defs.svh"

module rsfm_persist #(
	parameter int N = 2
) (
	// Clock and clear
	input  wire logic sys_clk_i,
	input  wire logic clear_i,
	// Condition
	input  wire logic arm_i,
	input  wire logic cond_i,
	// Confirmed
	output logic      hit_o
);

	logic [16:0] cnt;

	// Any drop of the condition starts the interval over
	always_ff @(posedge sys_clk_i) begin
		if (clear_i || !arm_i || !cond_i) begin
			cnt <= 17'h00000;
			hit_o <= 1'b0;
		end else if (cnt == 17'(N - 1)) begin
			hit_o <= 1'b1;
		end else begin
			cnt <= cnt + 17'h00001;
		end
	end

	a_persist_cause: assert property (
		@(posedge sys_clk_i) disable iff (clear_i)
		$rose(hit_o) |-> $past(arm_i && cond_i) && $past(cnt) == 17'(N - 1)
	) else $error("fault confirmed without full persistence");

endmodule

module rsfm_top #(
	parameter int HSOC_CYC  = `RSFM_CYC_US(`RSFM_T_HSOC_US),
	parameter int LSOC_CYC  = `RSFM_CYC_US(`RSFM_T_LSOC_US),
	parameter int STG_CYC   = `RSFM_CYC_US(`RSFM_T_STG_US),
	parameter int LEAK_CYC  = `RSFM_CYC_US(`RSFM_T_LEAK_US),
	parameter int BLANK_CYC = `RSFM_CYC_US(`RSFM_T_BLANK_US)
) (
	// Clock and resets
	input  wire logic              sys_clk_i,
	input  wire logic              reset_i,
	input  wire logic              safety_state_reset_i,
	input  wire logic              logic_self_test_i,
	// Analog comparators, asynchronous
	input  wire rsfm_pkg::rsfm_raw_t raw_i,
	// Channel low side on, same clock
	input  wire logic [3:0]        ls_on_i,
	// Register access
	input  wire rsfm_pkg::rsfm_req_t req_i,
	output logic [7:0]             reg_rdata_o,
	output logic                   reg_ack_o,
	// Channel power control
	output logic [3:0]             stage_en_o,
	output logic [3:0]             supply_connect_o,
	// Tracking regulators
	output logic [1:0]             trk_mode_o,
	output logic [1:0]             trk_en_o,
	output logic [1:0]             trk_ref_five_volt_o,
	// Decoded sensor data
	output logic [3:0]             decoded_speed_output_o
);

	localparam int STB_CYC  = `RSFM_CYC_US(`RSFM_T_STB_US);
	localparam int OPEN_CYC = `RSFM_CYC_US(`RSFM_T_OPEN_US);
	localparam logic [11:0] DGL_BASE = 12'(`RSFM_CYC_NS(`RSFM_T_DGL_MIN_NS));
	localparam logic [11:0] DGL_STEP = 12'(`RSFM_CYC_NS(`RSFM_T_DGL_STEP_NS));
	localparam logic [16:0] BLANK_LD = 17'(BLANK_CYC);

	rsfm_pkg::rsfm_raw_t raw_meta;
	rsfm_pkg::rsfm_raw_t raw_s;
	logic                soft_clr;
	logic                clr_all;
	logic [3:0]          hs_hit;
	logic [3:0]          ls_oc_hit;
	logic [3:0]          stb_hit;
	logic [3:0]          open_hit;
	logic [3:0]          stg_hit;
	logic [3:0]          leak_hit;
	logic [3:0]          blank_act;
	logic [3:0]          ls_oc_flag;
	logic [3:0]          stg_flag;
	logic [3:0]          hs_flag;
	logic [3:0]          open_flag;
	logic [3:0]          stb_flag;
	logic [3:0]          leak_flag;
	logic [5:0]          trk_stat;
	logic [3:0]          dgl_sel;
	logic [11:0]         dgl_tgt;
	logic [7:0]          next_rdata;

	assign soft_clr = safety_state_reset_i | logic_self_test_i;
	assign clr_all = reset_i | soft_clr;
	assign dgl_tgt = DGL_BASE + 12'(dgl_sel) * DGL_STEP;

	// Comparators are asynchronous to the core clock
	always_ff @(posedge sys_clk_i) begin
		raw_meta <= raw_i;
		raw_s <= raw_meta;
	end

	genvar ch;
	generate
		for (ch = 0; ch < 4; ch++) begin : g_ch
			logic [16:0] blank_cnt;
			logic        on_d;
			logic [11:0] dgl_cnt;

			// Restart blanking each time the channel turns on
			always_ff @(posedge sys_clk_i) begin
				on_d <= reset_i ? 1'b0 : ls_on_i[ch];
				if (reset_i) begin
					blank_cnt <= 17'h00000;
				end else if (ls_on_i[ch] && !on_d) begin
					blank_cnt <= BLANK_LD;
				end else if (blank_cnt != 17'h00000) begin
					blank_cnt <= blank_cnt - 17'h00001;
				end
			end
			assign blank_act[ch] = blank_cnt != 17'h00000;

			rsfm_persist #(.N(HSOC_CYC)) u_hs (
				.sys_clk_i (sys_clk_i),
				.clear_i   (clr_all),
				.arm_i     (stage_en_o[ch] && !blank_act[ch]),
				.cond_i    (raw_s.hs_oc[ch]),
				.hit_o     (hs_hit[ch])
			);
			rsfm_persist #(.N(LSOC_CYC)) u_ls (
				.sys_clk_i (sys_clk_i),
				.clear_i   (clr_all),
				.arm_i     (ls_on_i[ch]),
				.cond_i    (raw_s.ls_oc[ch]),
				.hit_o     (ls_oc_hit[ch])
			);
			rsfm_persist #(.N(STB_CYC)) u_stb (
				.sys_clk_i (sys_clk_i),
				.clear_i   (clr_all),
				.arm_i     (1'b1),
				.cond_i    (raw_s.stb[ch]),
				.hit_o     (stb_hit[ch])
			);
			// A lost supply pin also shows as an open return
			rsfm_persist #(.N(OPEN_CYC)) u_open (
				.sys_clk_i (sys_clk_i),
				.clear_i   (clr_all),
				.arm_i     (ls_on_i[ch]),
				.cond_i    (raw_s.open[ch]),
				.hit_o     (open_hit[ch])
			);
			rsfm_persist #(.N(STG_CYC)) u_stg (
				.sys_clk_i (sys_clk_i),
				.clear_i   (clr_all),
				.arm_i     (!ls_on_i[ch]),
				.cond_i    (raw_s.stg[ch]),
				.hit_o     (stg_hit[ch])
			);
			rsfm_persist #(.N(LEAK_CYC)) u_leak (
				.sys_clk_i (sys_clk_i),
				.clear_i   (clr_all),
				.arm_i     (1'b1),
				.cond_i    (raw_s.leak[ch]),
				.hit_o     (leak_hit[ch])
			);

			// Output follows the input only once it has been stable
			always_ff @(posedge sys_clk_i) begin
				if (reset_i) begin
					dgl_cnt <= 12'h000;
					decoded_speed_output_o[ch] <= 1'b0;
				end else if (raw_s.sense[ch] == decoded_speed_output_o[ch]) begin
					dgl_cnt <= 12'h000;
				end else if (dgl_cnt >= dgl_tgt - 12'h001) begin
					dgl_cnt <= 12'h000;
					decoded_speed_output_o[ch] <= raw_s.sense[ch];
				end else begin
					dgl_cnt <= dgl_cnt + 12'h001;
				end
			end
		end
	endgenerate

	// Flags are sticky; a new fault wins over a soft clear
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			ls_oc_flag <= 4'h0;
			stg_flag <= 4'h0;
		end else begin
			ls_oc_flag <= (ls_oc_flag & ~{4{soft_clr}}) | ls_oc_hit;
			stg_flag <= (stg_flag & ~{4{soft_clr}}) | stg_hit;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			hs_flag <= 4'h0;
			open_flag <= 4'h0;
			stb_flag <= 4'h0;
			leak_flag <= 4'h0;
		end else begin
			hs_flag <= (hs_flag & ~{4{soft_clr}}) | hs_hit;
			open_flag <= (open_flag & ~{4{soft_clr}}) | open_hit;
			stb_flag <= (stb_flag & ~{4{soft_clr}}) | stb_hit;
			leak_flag <= (leak_flag & ~{4{soft_clr}}) | leak_hit;
		end
	end

	// Stage stays off until a soft clear; low-side faults never reach here
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			stage_en_o <= 4'hf;
		end else begin
			stage_en_o <= (soft_clr ? 4'hf : stage_en_o) & ~hs_hit & ~raw_s.therm;
		end
	end

	// Disconnect is a level: the channel keeps running
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			supply_connect_o <= 4'hf;
		end else begin
			supply_connect_o <= ~stb_hit;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			trk_mode_o <= `RSFM_RST_TRK_MODE;
			trk_en_o <= `RSFM_RST_TRK_EN;
			trk_ref_five_volt_o <= `RSFM_RST_TRK_REF5;
			dgl_sel <= `RSFM_RST_DGL;
		end else if (req_i.access && req_i.write) begin
			if (req_i.addr == `RSFM_ADDR_TRK_CTRL) begin
				trk_en_o <= req_i.wdata[`RSFM_TRK_EN_LSB +: 2];
				trk_ref_five_volt_o <= req_i.wdata[`RSFM_TRK_REF5_LSB +: 2];
			end
			if (req_i.addr == `RSFM_ADDR_DGL) begin
				dgl_sel <= req_i.wdata[3:0];
			end
		end
	end

	// Tracker monitors only count while the tracker runs
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			trk_stat <= 6'h00;
		end else begin
			trk_stat <= {raw_s.trk_oc, raw_s.trk_uv, raw_s.trk_ov} & {3{trk_en_o & trk_mode_o}};
		end
	end

	always_comb begin
		case (req_i.addr)
			`RSFM_ADDR_STATUS:   next_rdata = {ls_oc_flag, stg_flag};
			`RSFM_ADDR_TRK_CTRL: next_rdata = {4'h0, trk_ref_five_volt_o, trk_en_o};
			`RSFM_ADDR_DGL:      next_rdata = {4'h0, dgl_sel};
			`RSFM_ADDR_TRK_STAT: next_rdata = {2'h0, trk_stat};
			`RSFM_ADDR_FLT_A:    next_rdata = {leak_flag, open_flag};
			`RSFM_ADDR_FLT_B:    next_rdata = {stb_flag, hs_flag};
			default:             next_rdata = 8'h00;
		endcase
	end

	// Read data is captured from flops, never mid-update
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			reg_rdata_o <= `RSFM_RST_STATUS;
			reg_ack_o <= 1'b0;
		end else begin
			reg_ack_o <= req_i.access;
			reg_rdata_o <= (req_i.access && !req_i.write) ? next_rdata : 8'h00;
		end
	end

	a_ls_oc_cause: assert property (
		@(posedge sys_clk_i) disable iff (reset_i)
		$rose(ls_oc_flag[2]) |-> $past(ls_on_i[2])
	) else $error("low-side overcurrent flagged while off");

	a_stg_cause: assert property (
		@(posedge sys_clk_i) disable iff (reset_i)
		$rose(stg_flag[1]) |-> !$past(ls_on_i[1])
	) else $error("short to ground flagged while on");

	a_trk_reset: assert property (
		@(posedge sys_clk_i)
		$past(reset_i) |-> trk_en_o == 2'h0 && trk_mode_o == 2'h3 && trk_ref_five_volt_o == 2'h0
	) else $error("tracker reset state wrong");

	a_ref_write: assert property (
		@(posedge sys_clk_i) disable iff (reset_i)
		req_i.access && req_i.write && req_i.addr == `RSFM_ADDR_TRK_CTRL
		|=> trk_ref_five_volt_o == $past(req_i.wdata[3:2])
	) else $error("reference select not taken");

	a_hs_shut: assert property (
		@(posedge sys_clk_i) disable iff (reset_i)
		hs_hit[0] |=> !stage_en_o[0]
	) else $error("stage left on after high-side overcurrent");

	a_therm_shut: assert property (
		@(posedge sys_clk_i) disable iff (reset_i)
		raw_s.therm != 4'h0 |=> (stage_en_o & $past(raw_s.therm)) == 4'h0
	) else $error("stage left on after thermal trip");

	a_stb_disc: assert property (
		@(posedge sys_clk_i) disable iff (reset_i)
		stb_hit[2] |=> !supply_connect_o[2] && (stage_en_o[2] || $past(!stage_en_o[2] || hs_hit[2] || raw_s.therm[2]))
	) else $error("short to battery not disconnected");

	a_blank_hold: assert property (
		@(posedge sys_clk_i) disable iff (reset_i)
		blank_act[0] |=> !$rose(hs_hit[0])
	) else $error("high-side fault during blanking");

	a_read_status: assert property (
		@(posedge sys_clk_i) disable iff (reset_i || soft_clr)
		req_i.access && !req_i.write && req_i.addr == `RSFM_ADDR_STATUS
		|=> reg_ack_o && reg_rdata_o == {$past(ls_oc_flag), $past(stg_flag)}
	) else $error("status read mismatch");

endmodule

// file: tb/rsfm_sensor_model.sv
// Comparator front end standing in for the sensors and their wiring
`timescale 1ns/10ps

module rsfm_sensor_model (
	// Clock
	input  wire logic                sys_clk_i,
	// Faults commanded by the scenario, slow reaction select
	input  wire rsfm_pkg::rsfm_raw_t fault_i,
	input  wire logic                slow_i,
	// Comparator levels seen by the device
	output rsfm_pkg::rsfm_raw_t      raw_o
);
	rsfm_pkg::rsfm_raw_t dly_a;
	rsfm_pkg::rsfm_raw_t dly_b;
	rsfm_pkg::rsfm_raw_t dly_c;

	// Slow analog settling, three clocks behind the fault
	always @(posedge sys_clk_i) begin
		dly_a <= fault_i;
		dly_b <= dly_a;
		dly_c <= dly_b;
	end

	// Comparators are asynchronous, so edges land away from the clock
	assign #1.7 raw_o = slow_i ? dly_c : fault_i;
endmodule

// file: tb/rsfm_top_test.sv
// Self-checking testbench of the sensor fault monitor
`timescale 1ns/10ps
`include "rsfm_defs.svh"

module rsfm_top_test;
	logic                sys_clk_i;
	logic                reset_i;
	logic                safety_state_reset_i;
	logic                logic_self_test_i;
	logic                slow;
	rsfm_pkg::rsfm_raw_t fault_cmd;
	rsfm_pkg::rsfm_raw_t raw;
	rsfm_pkg::rsfm_req_t req;
	logic [3:0]          ls_on;
	logic [7:0]          rdata;
	logic                ack;
	logic [3:0]          stage_en;
	logic [3:0]          supply_conn;
	logic [3:0]          decoded;
	logic [1:0]          trk_mode;
	logic [1:0]          trk_en;
	logic [1:0]          trk_ref;
	logic [7:0]          exp_q[$];
	logic [3:0]          sel;
	int                  error_cnt;
	int                  total_checks;
	int                  cyc;
	int                  seed;
	int                  n;
	int                  k;

	rsfm_sensor_model i_sensor (.sys_clk_i(sys_clk_i), .fault_i(fault_cmd), .slow_i(slow), .raw_o(raw));

	// Short filters keep the run brief
	rsfm_top #(.HSOC_CYC(20), .LSOC_CYC(20), .STG_CYC(30), .LEAK_CYC(10), .BLANK_CYC(16)) i_dut (
		.sys_clk_i(sys_clk_i), .reset_i(reset_i), .safety_state_reset_i(safety_state_reset_i),
		.logic_self_test_i(logic_self_test_i), .raw_i(raw), .ls_on_i(ls_on), .req_i(req),
		.reg_rdata_o(rdata), .reg_ack_o(ack), .stage_en_o(stage_en), .supply_connect_o(supply_conn),
		.trk_mode_o(trk_mode), .trk_en_o(trk_en), .trk_ref_five_volt_o(trk_ref),
		.decoded_speed_output_o(decoded));

	initial begin
		sys_clk_i = 1'b0;
		forever #2.5 sys_clk_i = ~sys_clk_i;
	end

	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic print_verdict;
		if (error_cnt == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic wt(input int c);
		repeat (c) @(negedge sys_clk_i);
	endtask

	// One register access; the answer is noted for the monitor
	task automatic acc(input logic w, input logic [6:0] a, input logic [7:0] d, input logic [7:0] e);
		exp_q.push_back(e);
		@(negedge sys_clk_i);
		req = '{access: 1'b1, write: w, addr: a, wdata: d};
		@(negedge sys_clk_i);
		req.access = 1'b0;
		@(negedge sys_clk_i);
	endtask

	task automatic pulse_clear(input logic self_test);
		@(negedge sys_clk_i);
		safety_state_reset_i = ~self_test;
		logic_self_test_i = self_test;
		@(negedge sys_clk_i);
		safety_state_reset_i = 1'b0;
		logic_self_test_i = 1'b0;
		wt(2);
	endtask

	// Read data monitor and hang guard; outputs looked at mid-cycle, once settled
	always @(negedge sys_clk_i) begin
		cyc++;
		if (ack === 1'b1) begin
			if (exp_q.size() == 0)
				chk("unexpected ack", 8'h01, 8'h00);
			else
				chk("reg_rdata", rdata, exp_q.pop_front());
		end
		if (cyc > 60000) begin
			error_cnt++;
			print_verdict();
		end
	end

	initial begin
		seed = 6621;
		error_cnt = 0;
		total_checks = 0;
		cyc = 0;
		reset_i = 1'b1;
		safety_state_reset_i = 1'b0;
		logic_self_test_i = 1'b0;
		slow = 1'b0;
		fault_cmd = '0;
		ls_on = 4'h0;
		req = '0;
		wt(6);
		reset_i = 1'b0;
		chk("trk_mode", 8'(trk_mode), 8'h03);
		chk("trk_en", 8'(trk_en), 8'h00);
		chk("trk_ref", 8'(trk_ref), 8'h00);
		acc(1'b0, `RSFM_ADDR_STATUS, 8'h00, 8'h00);
		acc(1'b0, 7'h7f, 8'h00, 8'h00);
		// Armed and unarmed faults side by side, plus a chattering one
		ls_on = 4'b1100;
		fault_cmd.ls_oc = 4'b0101;
		fault_cmd.stg = 4'b0110;
		for (k = 0; k < 6; k++) begin
			fault_cmd.ls_oc[3] = 1'b1;
			wt(12);
			fault_cmd.ls_oc[3] = 1'b0;
			wt(4);
		end
		acc(1'b0, `RSFM_ADDR_STATUS, 8'h00, 8'h42);
		chk("stage_en ls", 8'(stage_en), 8'h0f);
		fault_cmd.hs_oc[0] = 1'b1;
		wt(10);
		chk("stage_en early", 8'(stage_en), 8'h0f);
		wt(30);
		chk("stage_en hs", 8'(stage_en), 8'h0e);
		fault_cmd.therm[3] = 1'b1;
		wt(6);
		chk("stage_en therm", 8'(stage_en), 8'h06);
		fault_cmd = '0;
		wt(4);
		pulse_clear(1'b0);
		chk("stage_en clear", 8'(stage_en), 8'h0f);
		acc(1'b0, `RSFM_ADDR_STATUS, 8'h00, 8'h00);
		// Blanking after the low side turns on hides the high side fault
		// Held longer than the filter, so only blanking keeps the stage on
		ls_on = 4'b0001;
		fault_cmd.hs_oc[0] = 1'b1;
		wt(30);
		fault_cmd.hs_oc[0] = 1'b0;
		wt(30);
		chk("stage_en blank", 8'(stage_en), 8'h0f);
		// Short to battery with slow comparators, open sensor and leakage
		slow = 1'b1;
		ls_on = 4'b0010;
		fault_cmd.stb[2] = 1'b1;
		fault_cmd.open[1] = 1'b1;
		fault_cmd.leak[0] = 1'b1;
		wt(2100);
		chk("supply early", 8'(supply_conn), 8'h0f);
		wt(200);
		chk("supply stb", 8'(supply_conn), 8'h0b);
		chk("stage_en stb", 8'(stage_en), 8'h0f);
		acc(1'b0, `RSFM_ADDR_FLT_A, 8'h00, 8'h12);
		acc(1'b0, `RSFM_ADDR_FLT_B, 8'h00, 8'h40);
		fault_cmd = '0;
		wt(8);
		chk("supply back", 8'(supply_conn), 8'h0f);
		slow = 1'b0;
		pulse_clear(1'b1);
		acc(1'b0, `RSFM_ADDR_FLT_A, 8'h00, 8'h00);
		// Trackers: channel 0 on, both on the five-volt rail
		acc(1'b1, `RSFM_ADDR_TRK_CTRL, 8'h0d, 8'h00);
		chk("trk_en", 8'(trk_en), 8'h01);
		chk("trk_ref", 8'(trk_ref), 8'h03);
		fault_cmd.trk_ov = 2'b11;
		wt(5);
		acc(1'b0, `RSFM_ADDR_TRK_STAT, 8'h00, 8'h01);
		// Deglitch with a random setting
		sel = 4'($random(seed));
		acc(1'b1, `RSFM_ADDR_DGL, {4'h0, sel}, 8'h00);
		n = `RSFM_T_DGL_MIN_NS / `RSFM_CLK_NS + int'(sel) * (`RSFM_T_DGL_STEP_NS / `RSFM_CLK_NS);
		fault_cmd.sense[1] = 1'b1;
		wt(n);
		chk("decoded early", 8'(decoded), 8'h00);
		k = 0;
		while (decoded[1] !== 1'b1 && k < `RSFM_T_LAT_MAX_NS / `RSFM_CLK_NS) begin
			wt(1);
			k++;
		end
		chk("decoded", 8'(decoded), 8'h02);
		wt(4);
		chk("pending reads", 8'(exp_q.size()), 8'h00);
		print_verdict();
	end
endmodule
